// [src/bmn_block_ram.sv]
// 18 Kbit block memory with two configurable ports and a non-volatile shadow
//
// Notes on behaviour
// - 18 Kbit array, registered port inputs and outputs
// - single, true dual or pseudo dual port
// - depths 16K x1 down to 512 x36
// - 512 x36 refused in true dual port
// - each port picks its own width
// - bits packed LSB word 0 upward
// - optional parity bit per byte lane
// - byte enables on 18 and 36 bit widths
// - shadow loads array at reset and reconfigure
// - save request copies array into shadow
`timescale 1ns/1ns
`include "bmn_defines.svh"
module bmn_block_ram (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // configuration
  input wire bmn_pkg::bmn_mode_t mode,
  input wire bmn_pkg::bmn_width_t a_width,
  input wire bmn_pkg::bmn_width_t b_width,
  input wire logic parity_en,
  // shadow control
  input wire logic reconfig,
  input wire logic save_req,
  output logic busy_q,
  output logic cfg_err_q,
  // port a
  input wire logic a_en,
  input wire logic a_we,
  input wire logic [`BMN_ADDR_W-1:0] a_addr,
  input wire logic [`BMN_MAX_W-1:0] a_wdata,
  input wire logic [`BMN_LANES-1:0] a_be,
  output logic [`BMN_MAX_W-1:0] a_rdata_q,
  output logic a_rvalid_q,
  output logic a_perr_q,
  // port b
  input wire logic b_en,
  input wire logic b_we,
  input wire logic [`BMN_ADDR_W-1:0] b_addr,
  input wire logic [`BMN_MAX_W-1:0] b_wdata,
  input wire logic [`BMN_LANES-1:0] b_be,
  output logic [`BMN_MAX_W-1:0] b_rdata_q,
  output logic b_rvalid_q,
  output logic b_perr_q
);
  typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_SAVE} bmn_state_t;

  bmn_state_t st_q;
  bmn_state_t st_d;
  logic [`BMN_COPY_CW-1:0] cnt_q;
  logic [`BMN_BIT_AW-1:0] cp_base;

  // volatile array and its shadow; neither is reset, like real storage
  logic mem_q [0:`BMN_TOTAL_BITS-1];
  logic nv_q [0:`BMN_TOTAL_BITS-1];

  logic pa_rd;
  logic pa_wr;
  logic pb_rd;
  logic pb_wr;
  logic [`BMN_BIT_AW-1:0] a_base;
  logic [`BMN_BIT_AW-1:0] b_base;
  logic [`BMN_MAX_W-1:0] a_wmask;
  logic [`BMN_MAX_W-1:0] b_wmask;
  logic [`BMN_MAX_W-1:0] a_wd;
  logic [`BMN_MAX_W-1:0] b_wd;
  logic [`BMN_MAX_W-1:0] rd_a;
  logic [`BMN_MAX_W-1:0] rd_b;
  logic [5:0] a_nb;
  logic [5:0] b_nb;
  logic cfg_err_d;
  logic access_ok;
  logic a_rd_fire;
  logic a_wr_fire;
  logic b_rd_fire;
  logic b_wr_fire;

  bmn_port u_port_a (
    .clk(clk),
    .reset(reset),
    .width(a_width),
    .parity_en(parity_en),
    .en(a_en),
    .we(a_we),
    .addr(a_addr),
    .wdata(a_wdata),
    .be(a_be),
    .rd(pa_rd),
    .wr(pa_wr),
    .base(a_base),
    .wmask(a_wmask),
    .wdata_p(a_wd)
  );

  bmn_port u_port_b (
    .clk(clk),
    .reset(reset),
    .width(b_width),
    .parity_en(parity_en),
    .en(b_en),
    .we(b_we),
    .addr(b_addr),
    .wdata(b_wdata),
    .be(b_be),
    .rd(pb_rd),
    .wr(pb_wr),
    .base(b_base),
    .wmask(b_wmask),
    .wdata_p(b_wd)
  );

  assign a_nb = bmn_pkg::width_bits(a_width);
  assign b_nb = bmn_pkg::width_bits(b_width);

  // the 36 bit organisation needs both port paths, so two ports cannot have it
  assign cfg_err_d = (mode == bmn_pkg::MODE_TDP) &&
                     ((a_width == bmn_pkg::W36) || (b_width == bmn_pkg::W36));

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_err_q <= 1'b0;
    end else begin
      cfg_err_q <= cfg_err_d;
    end
  end

  // ports stay quiet while the shadow copy owns the array
  assign access_ok = (st_q == ST_IDLE) && !cfg_err_q;

  always_comb begin
    a_rd_fire = 1'b0;
    a_wr_fire = 1'b0;
    b_rd_fire = 1'b0;
    b_wr_fire = 1'b0;
    unique case (mode)
      bmn_pkg::MODE_SP: begin
        a_rd_fire = access_ok && pa_rd;
        a_wr_fire = access_ok && pa_wr;
      end
      bmn_pkg::MODE_TDP: begin
        a_rd_fire = access_ok && pa_rd;
        a_wr_fire = access_ok && pa_wr;
        b_rd_fire = access_ok && pb_rd;
        b_wr_fire = access_ok && pb_wr;
      end
      bmn_pkg::MODE_PDP: begin
        a_wr_fire = access_ok && pa_wr;
        b_rd_fire = access_ok && pb_rd;
      end
      default: begin
        a_rd_fire = 1'b0;
      end
    endcase
  end

  // reads see the array before this edge's writes land
  always_comb begin
    for (int i = 0; i < `BMN_MAX_W; i++) begin
      rd_a[i] = (6'(i) < a_nb) ? mem_q[a_base + `BMN_BIT_AW'(i)] : 1'b0;
      rd_b[i] = (6'(i) < b_nb) ? mem_q[b_base + `BMN_BIT_AW'(i)] : 1'b0;
    end
  end

  function automatic logic lane_bad(input logic [`BMN_MAX_W-1:0] d,
                                    input bmn_pkg::bmn_width_t w);
    logic bad;
    bad = 1'b0;
    for (int k = 0; k < `BMN_LANES; k++) begin
      if (3'(k) < bmn_pkg::lane_count(w)) begin
        bad = bad | (d[k*`BMN_LANE_W + 8] != ^d[k*`BMN_LANE_W +: 8]);
      end
    end
    lane_bad = bad;
  endfunction

  // shadow sequencer
  assign cp_base = {6'h00, cnt_q} * `BMN_BIT_AW'(`BMN_MAX_W);

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_LOAD: begin
        if (cnt_q == `BMN_COPY_LAST) begin
          st_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (reconfig) begin
          st_d = ST_LOAD;
        end else if (save_req) begin
          st_d = ST_SAVE;
        end
      end
      ST_SAVE: begin
        if (cnt_q == `BMN_COPY_LAST) begin
          st_d = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= ST_LOAD;
      busy_q <= 1'b1;
    end else begin
      st_q <= st_d;
      busy_q <= (st_d != ST_IDLE);
    end
  end

  always_ff @(posedge clk) begin
    if (reset || (st_q == ST_IDLE)) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + `BMN_COPY_CW'(1);
    end
  end

  // array writes: on a true dual port collision port a is applied last and wins
  always_ff @(posedge clk) begin
    if (st_q == ST_LOAD) begin
      for (int i = 0; i < `BMN_MAX_W; i++) begin
        mem_q[cp_base + `BMN_BIT_AW'(i)] <= nv_q[cp_base + `BMN_BIT_AW'(i)];
      end
    end else begin
      for (int i = 0; i < `BMN_MAX_W; i++) begin
        if (b_wr_fire && b_wmask[i]) begin
          mem_q[b_base + `BMN_BIT_AW'(i)] <= b_wd[i];
        end
      end
      for (int i = 0; i < `BMN_MAX_W; i++) begin
        if (a_wr_fire && a_wmask[i]) begin
          mem_q[a_base + `BMN_BIT_AW'(i)] <= a_wd[i];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (st_q == ST_SAVE) begin
      for (int i = 0; i < `BMN_MAX_W; i++) begin
        nv_q[cp_base + `BMN_BIT_AW'(i)] <= mem_q[cp_base + `BMN_BIT_AW'(i)];
      end
    end
  end

  // output registers; data hold until the next read on that port
  always_ff @(posedge clk) begin
    if (reset) begin
      a_rdata_q <= `BMN_RDATA_RST;
      a_rvalid_q <= 1'b0;
      a_perr_q <= 1'b0;
    end else begin
      a_rvalid_q <= a_rd_fire;
      a_perr_q <= a_rd_fire && parity_en && lane_bad(rd_a, a_width);
      if (a_rd_fire) begin
        a_rdata_q <= rd_a;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      b_rdata_q <= `BMN_RDATA_RST;
      b_rvalid_q <= 1'b0;
      b_perr_q <= 1'b0;
    end else begin
      b_rvalid_q <= b_rd_fire;
      b_perr_q <= b_rd_fire && parity_en && lane_bad(rd_b, b_width);
      if (b_rd_fire) begin
        b_rdata_q <= rd_b;
      end
    end
  end

  // checks
  sequence s_a_read_req;
    a_en && !a_we ##1 (!busy_q && !cfg_err_q && (mode != bmn_pkg::MODE_PDP));
  endsequence

  sequence s_save_start;
    save_req && !reconfig && (st_q == ST_IDLE);
  endsequence

  sequence s_copy_end;
    (st_q != ST_IDLE) && (cnt_q == `BMN_COPY_LAST);
  endsequence

  a_read_latency: assert property (@(posedge clk) disable iff (reset)
    s_a_read_req |=> a_rvalid_q)
    else $error("port a read did not answer two cycles after request");

  a_mode_paths: assert property (@(posedge clk) disable iff (reset)
    (mode == bmn_pkg::MODE_PDP) |-> !b_wr_fire ##1 !a_rvalid_q)
    else $error("pseudo dual port used a disallowed direction");

  a_single_port_b: assert property (@(posedge clk) disable iff (reset)
    (mode == bmn_pkg::MODE_SP) ##1 (mode == bmn_pkg::MODE_SP) |-> !b_rvalid_q)
    else $error("port b answered in single port mode");

  a_tdp_no_wide: assert property (@(posedge clk) disable iff (reset)
    cfg_err_d |=> cfg_err_q && !a_rd_fire && !a_wr_fire && !b_wr_fire)
    else $error("36 bit width accepted in true dual port mode");

  a_parity_gate: assert property (@(posedge clk) disable iff (reset)
    !$past(parity_en) |-> !a_perr_q && !b_perr_q)
    else $error("parity error flagged with parity disabled");

  a_reset_loads: assert property (@(posedge clk)
    reset |=> (st_q == ST_LOAD) && busy_q && (cnt_q == '0))
    else $error("reset did not start the shadow load");

  a_save_starts: assert property (@(posedge clk) disable iff (reset)
    s_save_start |=> (st_q == ST_SAVE) && busy_q ##1 (cnt_q == `BMN_COPY_CW'(1)))
    else $error("save request did not start the copy");

  a_copy_ends: assert property (@(posedge clk) disable iff (reset)
    s_copy_end |=> !busy_q && (st_q == ST_IDLE))
    else $error("busy did not drop after the last copy word");

  a_busy_blocks: assert property (@(posedge clk) disable iff (reset)
    busy_q |-> !a_wr_fire && !b_wr_fire ##1 !a_rvalid_q && !b_rvalid_q)
    else $error("port access taken while busy");

  a_pdp_old_data: assert property (@(posedge clk) disable iff (reset)
    b_rd_fire && a_wr_fire && (a_base == b_base) && (a_nb == b_nb)
    |=> b_rdata_q == $past(rd_b))
    else $error("collision read returned new data");
endmodule

// [src/bmn_defines.svh]
// constants for the block memory with non-volatile shadow
`ifndef BMN_DEFINES_SVH
`define BMN_DEFINES_SVH
`define BMN_TOTAL_BITS 18432
`define BMN_ADDR_W 14
`define BMN_BIT_AW 15
`define BMN_MAX_W 36
`define BMN_LANE_W 9
`define BMN_LANES 4
`define BMN_COPY_LAST 9'h1_FF
`define BMN_COPY_CW 9
`define BMN_RDATA_RST 36'h0_0000_0000
`endif

// [src/bmn_pkg.sv]
// types and width helpers for the block memory
`include "bmn_defines.svh"
package bmn_pkg;
  typedef enum logic [1:0] {MODE_SP, MODE_TDP, MODE_PDP} bmn_mode_t;
  typedef enum logic [2:0] {W1, W2, W4, W9, W18, W36} bmn_width_t;

  function automatic logic [5:0] width_bits(input bmn_width_t w);
    unique case (w)
      W1: width_bits = 6'h01;
      W2: width_bits = 6'h02;
      W4: width_bits = 6'h04;
      W9: width_bits = 6'h09;
      W18: width_bits = 6'h12;
      W36: width_bits = 6'h24;
      default: width_bits = 6'h01;
    endcase
  endfunction

  // word address bits that are live for each depth
  function automatic logic [13:0] addr_mask(input bmn_width_t w);
    unique case (w)
      W1: addr_mask = 14'h3_FFF;
      W2: addr_mask = 14'h1_FFF;
      W4: addr_mask = 14'h0_FFF;
      W9: addr_mask = 14'h0_7FF;
      W18: addr_mask = 14'h0_3FF;
      W36: addr_mask = 14'h0_1FF;
      default: addr_mask = 14'h0_000;
    endcase
  endfunction

  function automatic logic [2:0] lane_count(input bmn_width_t w);
    unique case (w)
      W9: lane_count = 3'h1;
      W18: lane_count = 3'h2;
      W36: lane_count = 3'h4;
      default: lane_count = 3'h0;
    endcase
  endfunction
endpackage

// [src/bmn_port.sv]
// one memory port: input registers, bit placement and write lane mask
`timescale 1ns/1ns
`include "bmn_defines.svh"
module bmn_port (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // configuration
  input wire bmn_pkg::bmn_width_t width,
  input wire logic parity_en,
  // fabric side
  input wire logic en,
  input wire logic we,
  input wire logic [`BMN_ADDR_W-1:0] addr,
  input wire logic [`BMN_MAX_W-1:0] wdata,
  input wire logic [`BMN_LANES-1:0] be,
  // registered request towards the array
  output logic rd,
  output logic wr,
  output logic [`BMN_BIT_AW-1:0] base,
  output logic [`BMN_MAX_W-1:0] wmask,
  output logic [`BMN_MAX_W-1:0] wdata_p
);
  logic en_q;
  logic we_q;
  logic [`BMN_ADDR_W-1:0] addr_q;
  logic [`BMN_MAX_W-1:0] wdata_q;
  logic [`BMN_LANES-1:0] be_q;
  logic [19:0] prod;
  logic [5:0] nb;
  logic byte_wide;

  always_ff @(posedge clk) begin
    if (reset) begin
      en_q <= 1'b0;
      we_q <= 1'b0;
    end else begin
      en_q <= en;
      we_q <= we;
    end
  end

  always_ff @(posedge clk) begin
    addr_q <= addr;
    wdata_q <= wdata;
    be_q <= be;
  end

  assign rd = en_q & ~we_q;
  assign wr = en_q & we_q;
  assign nb = bmn_pkg::width_bits(width);
  // word n of any width starts at bit n*width, so all widths share one layout
  assign prod = {6'h00, addr_q & bmn_pkg::addr_mask(width)} * {14'h0000, nb};
  assign base = prod[`BMN_BIT_AW-1:0];
  assign byte_wide = (width == bmn_pkg::W18) || (width == bmn_pkg::W36);

  always_comb begin
    for (int i = 0; i < `BMN_MAX_W; i++) begin
      wmask[i] = (6'(i) < nb) && (!byte_wide || be_q[i / `BMN_LANE_W]);
    end
  end

  always_comb begin
    wdata_p = wdata_q;
    for (int k = 0; k < `BMN_LANES; k++) begin
      if (parity_en && (3'(k) < bmn_pkg::lane_count(width))) begin
        wdata_p[k*`BMN_LANE_W + 8] = ^wdata_q[k*`BMN_LANE_W +: 8];
      end
    end
  end
endmodule

// [verif/bmn_fabric_model.sv]
// fabric-side partner that drives port b of the block memory
`timescale 1ns/1ns
module bmn_fabric_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // status from the memory
  input wire logic busy_q,
  // requests from the test
  input wire logic req,
  input wire logic req_we,
  input wire logic [13:0] req_addr,
  input wire logic [35:0] req_wdata,
  // port b of the memory
  output logic b_en,
  output logic b_we,
  output logic [13:0] b_addr,
  output logic [35:0] b_wdata,
  output logic [3:0] b_be
);
  // no queue pointers kept here: ordering of requests is left to the caller
  always_ff @(posedge clk) begin
    if (reset) begin
      b_en <= 1'b0;
      b_we <= 1'b0;
      b_addr <= 14'h0000;
      b_wdata <= 36'h0_0000_0000;
      b_be <= 4'h0;
    end else begin
      b_en <= req && !busy_q;
      // idle lines toggle so a stale value is never mistaken for a request
      b_we <= req ? req_we : ~b_we;
      b_addr <= req ? req_addr : ~b_addr;
      b_wdata <= req ? req_wdata : ~b_wdata;
      b_be <= req ? 4'hF : ~b_be;
    end
  end
endmodule

// [verif/bmn_block_ram_test.sv]
// self-checking bench for the block memory with shadow copy
`timescale 1ns/1ns
module bmn_block_ram_test;
  logic clk, reset, parity_en, reconfig, save_req, busy_q, cfg_err_q;
  bmn_pkg::bmn_mode_t mode;
  bmn_pkg::bmn_width_t a_width, b_width;
  logic a_en, a_we, a_rvalid_q, a_perr_q, b_en, b_we, b_rvalid_q, b_perr_q;
  logic req, req_we;
  logic [13:0] a_addr, b_addr, req_addr;
  logic [35:0] a_wdata, a_rdata_q, b_wdata, b_rdata_q, req_wdata;
  logic [3:0] a_be, b_be;
  int err_total, checks, n;

  bmn_block_ram dut_u (.clk(clk), .reset(reset), .mode(mode), .a_width(a_width),
    .b_width(b_width), .parity_en(parity_en), .reconfig(reconfig), .save_req(save_req),
    .busy_q(busy_q), .cfg_err_q(cfg_err_q), .a_en(a_en), .a_we(a_we), .a_addr(a_addr),
    .a_wdata(a_wdata), .a_be(a_be), .a_rdata_q(a_rdata_q), .a_rvalid_q(a_rvalid_q),
    .a_perr_q(a_perr_q), .b_en(b_en), .b_we(b_we), .b_addr(b_addr), .b_wdata(b_wdata),
    .b_be(b_be), .b_rdata_q(b_rdata_q), .b_rvalid_q(b_rvalid_q), .b_perr_q(b_perr_q));

  bmn_fabric_model fabric_u (.clk(clk), .reset(reset), .busy_q(busy_q), .req(req),
    .req_we(req_we), .req_addr(req_addr), .req_wdata(req_wdata), .b_en(b_en),
    .b_we(b_we), .b_addr(b_addr), .b_wdata(b_wdata), .b_be(b_be));

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic wr_a(input logic [13:0] ad, input logic [35:0] d, input logic [3:0] be);
    @(posedge clk);
    a_en <= 1'b1;
    a_we <= 1'b1;
    a_addr <= ad;
    a_wdata <= d;
    a_be <= be;
    @(posedge clk);
    a_en <= 1'b0;
    a_wdata <= ~d;
  endtask

  task automatic rd_a(input logic [13:0] ad, input logic [35:0] exp);
    @(posedge clk);
    a_en <= 1'b1;
    a_we <= 1'b0;
    a_addr <= ad;
    @(posedge clk);
    a_en <= 1'b0;
    @(posedge clk);
    #1;
    chk(a_rvalid_q, 36'h0_0000_0001);
    chk(a_rdata_q, exp);
  endtask

  // port b writes go through the fabric model, which adds one register stage
  task automatic wr_b(input logic [13:0] ad, input logic [35:0] d);
    @(posedge clk);
    req <= 1'b1;
    req_we <= 1'b1;
    req_addr <= ad;
    req_wdata <= d;
    @(posedge clk);
    req <= 1'b0;
  endtask

  // hit low means the read must be dropped; pe is the expected parity flag
  task automatic rd_b(input logic [13:0] ad, input logic [35:0] exp, input logic hit,
                      input logic pe);
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    req <= 1'b1;
    req_we <= 1'b0;
    req_addr <= ad;
    @(posedge clk);
    req <= 1'b0;
    repeat (4) begin
      @(posedge clk);
      #1;
      if (b_rvalid_q === 1'b1 && !seen) begin
        seen = 1'b1;
        chk(b_rdata_q, exp);
        chk(b_perr_q, pe);
      end
    end
    chk(seen, hit);
  endtask

  task automatic wait_idle(input int exp);
    n = 0;
    while (busy_q === 1'b1 && n < 1000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n, exp);
  endtask

  task automatic shadow(input logic rc);
    @(posedge clk);
    if (rc) reconfig <= 1'b1;
    else save_req <= 1'b1;
    @(posedge clk);
    reconfig <= 1'b0;
    save_req <= 1'b0;
    #1;
    wait_idle(512);
  endtask

  task automatic cfg(input bmn_pkg::bmn_mode_t m, input bmn_pkg::bmn_width_t aw, bw,
                     input logic p);
    @(posedge clk);
    mode <= m;
    a_width <= aw;
    b_width <= bw;
    parity_en <= p;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // about 2200 cycles of tests; the limit leaves wide margin
  initial begin
    #(40 * 20000);
    err_total++;
    give_verdict;
  end

  initial begin
    err_total = 0;
    checks = 0;
    reset = 1'b1;
    mode = bmn_pkg::MODE_SP;
    a_width = bmn_pkg::W36;
    b_width = bmn_pkg::W36;
    {parity_en, reconfig, save_req, a_en, a_we, req, req_we} = 7'h00;
    a_addr = 14'h0000;
    req_addr = 14'h0000;
    a_wdata = 36'h0_0000_0000;
    req_wdata = 36'h0_0000_0000;
    a_be = 4'h0;
    repeat (16) @(posedge clk);
    #1;
    chk(busy_q, 36'h0_0000_0001);
    @(posedge clk);
    reset <= 1'b0;
    #1;
    wait_idle(512);
    wr_a(14'h0002, 36'hF_FFFF_FFFF, 4'hF);
    wr_a(14'h0002, 36'h0_0000_0000, 4'h2);
    rd_a(14'h0002, 36'hF_FFFC_01FF);
    wr_a(14'h0003, 36'h1_2345_6789, 4'hF);
    fork
      shadow(1'b0);
      begin
        repeat (5) @(posedge clk);
        wr_a(14'h0003, 36'h0_AAAA_5555, 4'hF);
      end
    join
    rd_a(14'h0003, 36'h1_2345_6789);
    wr_a(14'h0003, 36'h0_0F0F_0F0F, 4'hF);
    shadow(1'b1);
    rd_a(14'h0003, 36'h1_2345_6789);
    cfg(bmn_pkg::MODE_SP, bmn_pkg::W9, bmn_pkg::W9, 1'b1);
    wr_a(14'h0007, 36'h0_0000_0007, 4'hF);
    rd_a(14'h0007, 36'h0_0000_0107);
    chk(a_perr_q, 36'h0_0000_0000);
    rd_b(14'h0007, 36'h0_0000_0000, 1'b0, 1'b0);
    // stored with parity off, so the parity bit is wrong once checking is on
    cfg(bmn_pkg::MODE_SP, bmn_pkg::W9, bmn_pkg::W9, 1'b0);
    wr_a(14'h0008, 36'h0_0000_0007, 4'hF);
    cfg(bmn_pkg::MODE_TDP, bmn_pkg::W9, bmn_pkg::W9, 1'b1);
    rd_a(14'h0008, 36'h0_0000_0007);
    chk(a_perr_q, 36'h0_0000_0001);
    rd_b(14'h0008, 36'h0_0000_0007, 1'b1, 1'b1);
    cfg(bmn_pkg::MODE_PDP, bmn_pkg::W18, bmn_pkg::W9, 1'b0);
    wr_a(14'h0000, 36'h0_0003_0155, 4'hF);
    rd_b(14'h0000, 36'h0_0000_0155, 1'b1, 1'b0);
    rd_b(14'h0001, 36'h0_0000_0180, 1'b1, 1'b0);
    cfg(bmn_pkg::MODE_PDP, bmn_pkg::W18, bmn_pkg::W4, 1'b0);
    rd_b(14'h0000, 36'h0_0000_0005, 1'b1, 1'b0);
    cfg(bmn_pkg::MODE_PDP, bmn_pkg::W18, bmn_pkg::W18, 1'b0);
    fork
      rd_b(14'h0000, 36'h0_0003_0155, 1'b1, 1'b0);
      begin
        @(posedge clk);
        wr_a(14'h0000, 36'h0_0001_1111, 4'hF);
      end
    join
    rd_b(14'h0000, 36'h0_0001_1111, 1'b1, 1'b0);
    cfg(bmn_pkg::MODE_TDP, bmn_pkg::W36, bmn_pkg::W18, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    chk(cfg_err_q, 36'h0_0000_0001);
    rd_b(14'h0000, 36'h0_0000_0000, 1'b0, 1'b0);
    cfg(bmn_pkg::MODE_TDP, bmn_pkg::W18, bmn_pkg::W18, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    chk(cfg_err_q, 36'h0_0000_0000);
    rd_a(14'h0000, 36'h0_0001_1111);
    rd_b(14'h0000, 36'h0_0001_1111, 1'b1, 1'b0);
    cfg(bmn_pkg::MODE_TDP, bmn_pkg::W18, bmn_pkg::W9, 1'b0);
    wr_b(14'h0001, 36'h0_0000_00AA);
    rd_a(14'h0000, 36'h0_0001_5511);
    cfg(bmn_pkg::MODE_TDP, bmn_pkg::W18, bmn_pkg::W2, 1'b0);
    rd_b(14'h0005, 36'h0_0000_0001, 1'b1, 1'b0);
    cfg(bmn_pkg::MODE_TDP, bmn_pkg::W18, bmn_pkg::W1, 1'b0);
    rd_b(14'h000A, 36'h0_0000_0001, 1'b1, 1'b0);
    // a second reset must bring back the saved shadow, not keep the array
    cfg(bmn_pkg::MODE_SP, bmn_pkg::W36, bmn_pkg::W36, 1'b0);
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    #1;
    chk(busy_q, 36'h0_0000_0001);
    chk(a_rdata_q, 36'h0_0000_0000);
    chk(b_rdata_q, 36'h0_0000_0000);
    wait_idle(512);
    rd_a(14'h0002, 36'hF_FFFC_01FF);
    rd_a(14'h0003, 36'h1_2345_6789);
    give_verdict;
  end
endmodule
